// File: verilog/port_host_ctrl.sv
// Controller that drives one port of the shared dual-port RAM by its pins.
`timescale 1ns/10ps
module port_host_ctrl
  import port_host_pkg::*;
#(
  parameter int ADDR_W  = port_host_pkg::ADDR_W_FULL,
  parameter bit IS_LEFT = 1'b1
) (
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  input  wire logic                            cmd_valid,
  input  wire port_host_pkg::op_e              cmd_op,
  input  wire logic [ADDR_W-1:0]               cmd_addr,
  input  wire logic [port_host_pkg::DATA_W-1:0] cmd_data,
  output logic                                 cmd_ready,
  output logic                                 rsp_valid,
  output logic [port_host_pkg::DATA_W-1:0]     rsp_data,
  output logic                                 rsp_denied,
  output logic                                 rsp_retried,
  input  wire logic                            lock_writes,
  output logic                                 irq_pending,
  output logic [ADDR_W-1:0]                    pin_addr,
  output logic                                 port_enable_low_active,
  output logic                                 port_enable_high_active,
  output logic                                 token_space_select_n,
  output logic                                 pin_rw_n,
  output logic                                 pin_oe_n,
  output logic [port_host_pkg::DATA_W-1:0]     pin_data_out,
  output logic                                 pin_data_oe,
  input  wire logic [port_host_pkg::DATA_W-1:0] pin_data_in,
  input  wire logic                            conflict_n,
  input  wire logic                            mailbox_irq_n,
  output logic                                 write_lock_n
);

  import port_host_pkg::*;

  typedef enum logic [2:0] {
    S_INIT, S_IDLE, S_SETUP, S_STROBE, S_RECOVER, S_DONE
  } state_e;

  // Mailbox words sit at the top of the address space of this depth.
  function automatic logic [ADDR_W-1:0] mbox_addr(input logic left_box);
    mbox_addr = {{(ADDR_W-1){1'b1}}, ~left_box};
  endfunction

  state_e              state_r,   state_nxt;
  op_e                 op_r,      op_nxt;
  logic [1:0]          step_r,    step_nxt;
  logic                wr_r,      wr_nxt;
  logic                sem_r,     sem_nxt;
  logic [ADDR_W-1:0]   addr_r,    addr_nxt;
  logic [DATA_W-1:0]   wdata_r,   wdata_nxt;
  logic                again_r,   again_nxt;
  logic                init_r,    init_nxt;
  logic                rv_r,      rv_nxt;
  logic [DATA_W-1:0]   rd_r,      rd_nxt;
  logic                den_r,     den_nxt;
  logic                ret_r,     ret_nxt;
  logic                rdy_r,     rdy_nxt;
  logic                irq_r;
  logic                lock_n_r;
  logic                ce0n_r,    ce0n_nxt;
  logic                ce1_r,     ce1_nxt;
  logic                semn_r,    semn_nxt;
  logic                rwn_r,     rwn_nxt;
  logic                oen_r,     oen_nxt;
  logic                doe_r,     doe_nxt;
  logic                active;
  logic                tmr_start;
  logic [TMR_W-1:0]    tmr_load;
  logic                tmr_expire;

  strobe_timer #(.CNT_W(TMR_W)) u_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .start   (tmr_start),
    .load    (tmr_load),
    .expire  (tmr_expire)
  );

  // Sequencer: every access is setup, strobe, then one recovery cycle.
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    step_nxt  = step_r;
    wr_nxt    = wr_r;
    sem_nxt   = sem_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    again_nxt = again_r;
    init_nxt  = init_r;
    rd_nxt    = rd_r;
    den_nxt   = den_r;
    ret_nxt   = ret_r;
    rv_nxt    = 1'b0;
    tmr_start = 1'b0;
    tmr_load  = TMR_W'(SETUP_CYC);
    case (state_r)
      S_INIT: begin
        // Read our own mailbox once so its flag starts cleared.
        op_nxt    = OP_MBOX_ACK;
        addr_nxt  = mbox_addr(IS_LEFT);
        wr_nxt    = 1'b0;
        sem_nxt   = 1'b0;
        step_nxt  = 2'd0;
        init_nxt  = 1'b1;
        tmr_start = 1'b1;
        state_nxt = S_SETUP;
      end
      S_IDLE: begin
        if (cmd_valid) begin
          op_nxt    = cmd_op;
          step_nxt  = 2'd0;
          den_nxt   = 1'b0;
          ret_nxt   = 1'b0;
          wr_nxt    = 1'b1;
          sem_nxt   = 1'b0;
          addr_nxt  = cmd_addr;
          wdata_nxt = cmd_data;
          case (cmd_op)
            OP_READ:      wr_nxt = 1'b0;
            OP_WRITE:     wr_nxt = 1'b1;
            OP_SEM_TAKE,
            OP_SEM_GIVE: begin
              // Token space uses the low three address bits only.
              sem_nxt   = 1'b1;
              addr_nxt  = {{(ADDR_W-SEM_ADDR_W){1'b0}},
                           cmd_addr[SEM_ADDR_W-1:0]};
              wdata_nxt = {DATA_W{cmd_op == OP_SEM_GIVE}};
            end
            OP_MBOX_SEND: addr_nxt = mbox_addr(!IS_LEFT);
            OP_MBOX_ACK: begin
              wr_nxt   = 1'b0;
              addr_nxt = mbox_addr(IS_LEFT);
            end
            default:      wr_nxt = 1'b0;
          endcase
          tmr_start = 1'b1;
          state_nxt = S_SETUP;
        end
      end
      S_SETUP: begin
        // Address and enables are held until the conflict flag settles.
        if (tmr_expire) begin
          tmr_start = 1'b1;
          tmr_load  = TMR_W'(ACCESS_CYC);
          state_nxt = S_STROBE;
        end
      end
      S_STROBE: begin
        if (tmr_expire) begin
          // An inhibited write is repeated after the recovery cycle, until a strobe ends unflagged.
          // One master's conflict line decides for every slave of the word.
          if (wr_r && !sem_r && !conflict_n) begin
            again_nxt = 1'b1;
            ret_nxt   = 1'b1;
          end
          if (!wr_r) begin
            rd_nxt = pin_data_in;
          end
          state_nxt = S_RECOVER;
        end
      end
      S_RECOVER: begin
        tmr_start = 1'b1;
        state_nxt = S_SETUP;
        if (again_r) begin
          again_nxt = 1'b0;
        end else if (op_r == OP_SEM_TAKE && step_r == 2'd0) begin
          step_nxt = 2'd1;
          wr_nxt   = 1'b0;
        end else if (op_r == OP_SEM_TAKE && step_r == 2'd1 && rd_r[0]) begin
          // Lost the token: withdraw the pending request.
          step_nxt  = 2'd2;
          den_nxt   = 1'b1;
          wr_nxt    = 1'b1;
          wdata_nxt = {DATA_W{1'b1}};
        end else begin
          tmr_start = 1'b0;
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        rv_nxt    = !init_r;
        init_nxt  = 1'b0;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Pin levels follow the next state so they leave flip-flops directly.
  always_comb begin
    active   = (state_nxt == S_SETUP) || (state_nxt == S_STROBE)
               || (state_nxt == S_RECOVER);
    ce0n_nxt = !(active && !sem_nxt);
    ce1_nxt  = active && !sem_nxt;
    semn_nxt = !(active && sem_nxt);
    rwn_nxt  = !((state_nxt == S_STROBE) && wr_nxt);
    oen_nxt  = !((state_nxt == S_STROBE) && !wr_nxt);
    doe_nxt  = wr_nxt && ((state_nxt == S_SETUP)
               || (state_nxt == S_STROBE));
    rdy_nxt  = (state_nxt == S_IDLE);
  end

  // Registers only; idle pins park the port in standby.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= S_INIT;
      op_r     <= OP_READ;
      step_r   <= 2'd0;
      wr_r     <= 1'b0;
      sem_r    <= 1'b0;
      addr_r   <= '0;
      wdata_r  <= '0;
      again_r  <= 1'b0;
      init_r   <= 1'b0;
      rv_r     <= 1'b0;
      rd_r     <= '0;
      den_r    <= 1'b0;
      ret_r    <= 1'b0;
      rdy_r    <= 1'b0;
      irq_r    <= 1'b0;
      lock_n_r <= 1'b1;
      ce0n_r   <= 1'b1;
      ce1_r    <= 1'b0;
      semn_r   <= 1'b1;
      rwn_r    <= 1'b1;
      oen_r    <= 1'b1;
      doe_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      step_r   <= step_nxt;
      wr_r     <= wr_nxt;
      sem_r    <= sem_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      again_r  <= again_nxt;
      init_r   <= init_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      den_r    <= den_nxt;
      ret_r    <= ret_nxt;
      rdy_r    <= rdy_nxt;
      irq_r    <= !mailbox_irq_n;
      lock_n_r <= !lock_writes;
      ce0n_r   <= ce0n_nxt;
      ce1_r    <= ce1_nxt;
      semn_r   <= semn_nxt;
      rwn_r    <= rwn_nxt;
      oen_r    <= oen_nxt;
      doe_r    <= doe_nxt;
    end
  end

  assign cmd_ready               = rdy_r;
  assign rsp_valid               = rv_r;
  assign rsp_data                = rd_r;
  assign rsp_denied              = den_r;
  assign rsp_retried             = ret_r;
  assign irq_pending             = irq_r;
  assign pin_addr                = addr_r;
  assign port_enable_low_active  = ce0n_r;
  assign port_enable_high_active = ce1_r;
  assign token_space_select_n    = semn_r;
  assign pin_rw_n                = rwn_r;
  assign pin_oe_n                = oen_r;
  assign pin_data_out            = wdata_r;
  assign pin_data_oe             = doe_r;
  assign write_lock_n            = lock_n_r;

  // Helper: data bit 0 of the most recent token-space write.
  logic last_sem_bit_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      last_sem_bit_r <= 1'b0;
    end else if (!rwn_r && !semn_r) begin
      last_sem_bit_r <= wdata_r[0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_strobe_setup_held: assert property (
    $fell(pin_rw_n) |-> $past(pin_addr, 2) == pin_addr
                        && $past(ce1_r, 2) == ce1_r
                        && $past(semn_r, 2) == semn_r)
    else $error("Write strobe began before address settled.");
  a_token_select_pins: assert property (
    !token_space_select_n |-> port_enable_low_active
                              && !port_enable_high_active)
    else $error("Token space reached with memory enables active.");
  a_lock_follows_input: assert property (
    ##1 write_lock_n == !$past(lock_writes))
    else $error("Write lock output does not follow its request.");
  a_withdraw_after_loss: assert property (
    rsp_valid && rsp_denied |-> last_sem_bit_r && $past(pin_rw_n, 2))
    else $error("Lost token request was not withdrawn.");
  a_init_reads_mailbox: assert property (
    init_r && !pin_oe_n |-> pin_addr == mbox_addr(IS_LEFT))
    else $error("Start-up mailbox read used the wrong address.");
  a_init_blocks_cmds: assert property (
    init_r |-> !cmd_ready)
    else $error("Commands accepted before mailbox initialised.");
  a_strobes_exclusive: assert property (
    !(!pin_oe_n && !pin_rw_n) && (!pin_data_oe || pin_oe_n))
    else $error("Read and write strobes overlap.");
  a_retry_on_conflict: assert property (
    state_r == S_STROBE && tmr_expire && wr_r && !sem_r && !conflict_n
    |-> ##2 state_r == S_SETUP ##1 pin_addr == $past(pin_addr, 3))
    else $error("Inhibited write was not repeated.");

  c_sem_denied:   cover property (rsp_valid && rsp_denied);
  c_sem_taken:    cover property (rsp_valid && op_r == OP_SEM_TAKE
                                  && !rsp_denied);
  c_write_retry:  cover property (rsp_valid && rsp_retried);
  c_mbox_ack:     cover property (rsp_valid && op_r == OP_MBOX_ACK);

endmodule // port_host_ctrl

// File: pkg/port_host_pkg.sv
// Constants and types shared by the dual-port RAM port controller.
// Summary of operation
// - System logic ties a slave conflict input high, or low to lock writes.
// - A width-expanded array uses exactly one master part.
// - Hold address and enable until the conflict settles before strobing.
// - Semaphore access: low-active enable high, high-active low, select low.
// - Both mailbox flags must be initialised by activity after power-up.
// - A failed request is followed by reads or by writing 1 to withdraw.
package port_host_pkg;

  localparam int ADDR_W_FULL = 19;
  localparam int DATA_W      = 18;
  localparam int SEM_ADDR_W  = 3;
  localparam int SEM_COUNT   = 8;

  // Clock period as a time; pin timing as a time and a derived cycle count.
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_SETUP_NS    = 20;
  localparam int T_ACCESS_NS   = 15;
  localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int TMR_W         = 4;

  // Commands accepted on the user side.
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_SEM_TAKE,
    OP_SEM_GIVE,
    OP_MBOX_SEND,
    OP_MBOX_ACK
  } op_e;

endpackage

// File: verilog/strobe_timer.sv
// Divider that emits a one-cycle expiry pulse a loaded number of cycles on.
`timescale 1ns/10ps
module strobe_timer #(
  parameter int CNT_W = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  expire
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             expire_r;
  logic             expire_nxt;

  // A fresh start always wins, so a stale count can never fire early.
  always_comb begin
    cnt_nxt    = cnt_r;
    expire_nxt = 1'b0;
    if (start) begin
      cnt_nxt = load;
    end else if (cnt_r != '0) begin
      cnt_nxt    = cnt_r - 1'b1;
      expire_nxt = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r    <= '0;
      expire_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign expire = expire_r;

endmodule // strobe_timer

// File: verification/dpram_model.sv
// Behavioural model of the shared dual-port RAM as a master part.
`timescale 1ns/10ps
module dpram_model #(
  parameter int ADDR_W = 19
) (
  input  wire logic [1:0][ADDR_W-1:0]                addr,
  input  wire logic [1:0]                            ce0,
  input  wire logic [1:0]                            ce1,
  input  wire logic [1:0]                            sem_n,
  input  wire logic [1:0]                            rw_n,
  input  wire logic [1:0]                            oe_n,
  input  wire logic [1:0][port_host_pkg::DATA_W-1:0] dout,
  input  wire logic [1:0]                            doe,
  output logic [1:0][port_host_pkg::DATA_W-1:0]      din,
  output logic [1:0]                                 conf_n,
  output logic [1:0]                                 irq_n
);
  import port_host_pkg::*;
  localparam int MB0 = 2**ADDR_W - 2;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] junk = 18'h2AAAA;
  int                own [SEM_COUNT];
  logic [1:0]        req [SEM_COUNT];
  time               stamp [2];
  logic [1:0]        sel;
  logic [1:0]        semx;

  // Select decode; a port with either enable inactive sits in standby, unless both are inactive with its token select low.
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      sel[s]  = !ce0[s] && ce1[s];
      semx[s] = ce0[s] && !ce1[s] && !sem_n[s];
    end
  end

  // Released lines wander, so a stale value is never read back by luck.
  always #10 junk = ~junk;

  // Settle time of each port's address and enable, used to pick a loser.
  always @(addr[0] or sel[0]) stamp[0] = $time;
  always @(addr[1] or sel[1]) stamp[1] = $time;

  // Push-pull arbitration; the model flags the right port on exact ties.
  always @* begin
    conf_n = 2'b11;
    if (sel[0] && sel[1] && addr[0] == addr[1]) begin
      if (stamp[1] >= stamp[0]) conf_n[1] = 1'b0;
      else conf_n[0] = 1'b0;
    end
  end

  // Read path; a token value is spread over every data bit.
  always @* begin
    for (int s = 0; s < 2; s++) begin
      if (doe[s]) din[s] = dout[s];
      else if (sel[s] && !oe_n[s] && rw_n[s])
        din[s] = mem.exists(int'(addr[s])) ? mem[int'(addr[s])] : junk;
      else if (semx[s] && !oe_n[s])
        din[s] = {DATA_W{own[addr[s][2:0]] != s + 1}};
      else din[s] = ~junk;
    end
  end

  // A port touching its own mailbox with output enable low drops its flag.
  always @* begin
    for (int s = 0; s < 2; s++)
      if (sel[s] && !oe_n[s] && int'(addr[s]) == MB0 + s)
        irq_n[s] = 1'b1;
  end

  // Writes land on the strobe's falling edge; flagged writes are dropped.
  task automatic commit(input int s);
    int o;
    int k;
    o = 1 - s;
    k = addr[s][2:0];
    if (sel[s] && conf_n[s]) begin
      mem[int'(addr[s])] = dout[s];
      if (int'(addr[s]) == MB0 + o) irq_n[o] = 1'b0;
    end else if (semx[s] && !dout[s][0]) begin
      if (own[k] == 0) own[k] = s + 1;
      else if (own[k] != s + 1) req[k][s] = 1'b1;
    end else if (semx[s]) begin
      req[k][s] = 1'b0;
      if (own[k] == s + 1) own[k] = req[k][o] ? o + 1 : 0;
      if (own[k] == o + 1) req[k][o] = 1'b0;
    end
  endtask

  always @(negedge rw_n[0]) commit(0);
  always @(negedge rw_n[1]) commit(1);

  // Tokens start free; mailbox flags start raised, as power-up leaves them.
  initial begin
    irq_n = 2'b00;
    for (int k = 0; k < SEM_COUNT; k++) begin
      own[k] = 0;
      req[k] = 2'b00;
    end
  end
endmodule // dpram_model

// File: verification/testbench.sv
// Self-checking bench: left and right controllers sharing the RAM model.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import port_host_pkg::*;
  localparam int AW = 19;
  logic                   clk_sys;
  logic                   reset_n;
  logic [1:0]             cv;
  logic [1:0]             lockw;
  op_e                    op [2];
  logic [1:0][AW-1:0]     ca;
  logic [1:0][DATA_W-1:0] cd;
  wire  [1:0]             rdy, rv, den, ret, irqp, wl_n;
  wire  [1:0]             ce0, ce1, semn, rwn, oen, doe, cfn, irqn;
  wire  [1:0][AW-1:0]     pa;
  wire  [1:0][DATA_W-1:0] rdat, pdo, pdi;
  int                     bad_count = 0;
  int                     tests_run = 0;

  // Slot 0 is the left port controller, slot 1 the right one.
  for (genvar s = 0; s < 2; s++) begin : g_port
    port_host_ctrl #(.ADDR_W(AW), .IS_LEFT(s == 0)) dut_u (
      .clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cv[s]),
      .cmd_op(op[s]), .cmd_addr(ca[s]), .cmd_data(cd[s]),
      .cmd_ready(rdy[s]), .rsp_valid(rv[s]), .rsp_data(rdat[s]),
      .rsp_denied(den[s]), .rsp_retried(ret[s]), .lock_writes(lockw[s]),
      .irq_pending(irqp[s]), .pin_addr(pa[s]),
      .port_enable_low_active(ce0[s]), .port_enable_high_active(ce1[s]),
      .token_space_select_n(semn[s]), .pin_rw_n(rwn[s]),
      .pin_oe_n(oen[s]), .pin_data_out(pdo[s]), .pin_data_oe(doe[s]),
      .pin_data_in(pdi[s]), .conflict_n(cfn[s]),
      .mailbox_irq_n(irqn[s]), .write_lock_n(wl_n[s]));
  end

  dpram_model #(.ADDR_W(AW)) ram_u (
    .addr(pa), .ce0(ce0), .ce1(ce1), .sem_n(semn), .rw_n(rwn),
    .oe_n(oen), .dout(pdo), .doe(doe), .din(pdi), .conf_n(cfn),
    .irq_n(irqn));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Settled sample point each cycle; a runaway wait ends the run.
  task automatic tick(inout int n);
    @(posedge clk_sys);
    #1;
    n++;
    if (n > 400) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, 400);
      conclude();
    end
  endtask

  // Offer one command once ready, then wait for its completion pulse.
  task automatic cmd(input int s, input op_e o, input int a, input int d);
    int n;
    n = 0;
    while (rdy[s] !== 1'b1) tick(n);
    cv[s] = 1'b1;
    op[s] = o;
    ca[s] = AW'(a);
    cd[s] = DATA_W'(d);
    tick(n);
    cv[s] = 1'b0;
    while (rv[s] !== 1'b1) tick(n);
  endtask

  // The startup mailbox read must clear the flags raised at power-up.
  task automatic t_start();
    int n;
    n = 0;
    while (rdy !== 2'b11) tick(n);
    `CHK(irqp, 2'b00)
    `CHK({ce0, ce1, semn, doe}, 8'hCC)
    $display("test start done");
  endtask

  // Cross-port write and read, the left mailbox word used as plain memory.
  task automatic t_rw();
    int a [3] = '{0, 'h2AAAA, 'h7FFFE};
    foreach (a[i]) begin
      cmd(0, OP_WRITE, a[i], 'h12345 + i);
      cmd(1, OP_READ, a[i], 0);
      `CHK(rdat[1], DATA_W'('h12345 + i))
    end
    `CHK({irqp, ce0, ce1, doe}, 8'h30)
    $display("test read write done");
  endtask

  // Mailbox in both directions: send raises, the receiver's read clears.
  task automatic t_mbox();
    for (int s = 0; s < 2; s++) begin
      cmd(s, OP_MBOX_SEND, 0, 'h3A5C0 + s);
      `CHK(irqp, 2'(1 << (1 - s)))
      cmd(1 - s, OP_MBOX_ACK, 0, 0);
      `CHK(rdat[1 - s], DATA_W'('h3A5C0 + s))
      `CHK(irqp, 2'b00)
    end
    $display("test mailbox done");
  endtask

  // Every token: win, lose to the holder, release, win from the other side.
  task automatic t_sem();
    for (int k = 0; k < SEM_COUNT; k++) begin
      cmd(0, OP_SEM_TAKE, k, 0);
      `CHK({den[0], rdat[0]}, 19'h00000)
      cmd(1, OP_SEM_TAKE, k, 0);
      `CHK({den[1], rdat[1]}, 19'h7FFFF)
      cmd(0, OP_SEM_GIVE, k, 0);
      cmd(1, OP_SEM_TAKE, k, 0);
      `CHK(den[1], 1'b0)
      cmd(1, OP_SEM_GIVE, k, 0);
    end
    $display("test semaphore done");
  endtask

  // Right writes one cycle behind left: same address by write or read,
  // then a different address that must not be flagged.
  task automatic t_conflict();
    for (int i = 0; i < 3; i++) begin
      fork
        cmd(0, op_e'(i == 1 ? OP_READ : OP_WRITE), 'h100, 'h111);
        begin
          int n = 0;
          tick(n);
          cmd(1, OP_WRITE, 'h100 + (i == 2), 'h222 + i);
        end
      join
      `CHK({ret[0], ret[1]}, {1'b0, i != 2})
      cmd(0, OP_READ, 'h100 + (i == 2), 0);
      `CHK(rdat[0], DATA_W'('h222 + i))
    end
    $display("test conflict done");
  endtask

  // Slave write lock follows the request with one cycle of delay.
  task automatic t_lock();
    int n;
    n = 0;
    lockw = 2'b01;
    tick(n);
    tick(n);
    `CHK(wl_n, 2'b10)
    lockw = 2'b10;
    tick(n);
    tick(n);
    `CHK(wl_n, 2'b01)
    lockw = 2'b00;
    $display("test lock done");
  endtask

  initial begin
    reset_n = 1'b0;
    cv = 2'b00;
    lockw = 2'b00;
    ca = '0;
    cd = '0;
    op[0] = OP_READ;
    op[1] = OP_READ;
    repeat (8) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_start();
    t_rw();
    t_mbox();
    t_sem();
    t_conflict();
    t_lock();
    conclude();
  end
endmodule // testbench
